/* File: i2ctt_core.sv */
// Summary of operation
// - local ack option clear and forward link down: never drive local acknowledge.
// - local ack option set: acknowledge locally while link down; resets set.
// - two-bit setup/hold select maps to four interval pairs, default code 01.
// - three-bit select sets remote master bit rate, 8.47k up to 837k.
// - two-bit timeout select: about 64, 256 or 1024 microseconds.
// - timeout code 11 means wait forever for the remote answer.
// - rate field sits in bits 4..2, 011=105k, 100=173k, default 101.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module i2ctt_core
  import i2ctt_pkg::*;
#(
  parameter int unsigned RATE0_HALF_CYC = rate_half(RATE_10BPS[0]),
  parameter int unsigned TMO0_CYC = TMO_US[0] * CLK_MHZ,
  parameter int unsigned TMO1_CYC = TMO_US[1] * CLK_MHZ,
  parameter int unsigned TMO2_CYC = TMO_US[2] * CLK_MHZ
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // slave-side engine
  input wire logic FWD_LINK_UP,
  input wire logic ACK_SLOT,
  input wire logic XFER_START,
  input wire logic REMOTE_RESP,
  output logic LOCAL_ACK,
  output logic STRETCH,
  output logic ABANDON,
  // timing to the bit engines
  output logic [7:0] SETUP_CYC,
  output logic [7:0] HOLD_CYC,
  output logic [15:0] HALF_BIT_CYC
);

  // the wait counter is 20 bits and the half period 16 bits wide
  if (TMO0_CYC < 2 || TMO1_CYC < 2 || TMO2_CYC < 2 || TMO2_CYC >= (1 << 20))
  begin : gen_bad_tmo
    $error("i2ctt_core: timeout counts out of range");
  end
  if (RATE0_HALF_CYC < 1 || RATE0_HALF_CYC >= (1 << 16))
  begin : gen_bad_rate
    $error("i2ctt_core: slowest rate count out of range");
  end

  logic [7:0] setup_tab [4];
  logic [7:0] hold_tab [4];
  logic [15:0] half_tab [8];

  // setup and hold round up so the bus never gets less than asked
  for (genvar g = 0; g < 4; g++)
  begin : gen_sh
    assign setup_tab[g] = 8'(ns_to_cyc(SETUP_NS[g]));
    assign hold_tab[g] = 8'(ns_to_cyc(HOLD_NS[g]));
  end

  // slowest entry is a parameter so a short run can still reach it
  for (genvar g = 0; g < 8; g++)
  begin : gen_half
    if (g == 0)
    begin : gen_slow
      assign half_tab[g] = 16'(RATE0_HALF_CYC);
    end
    else
    begin : gen_fast
      assign half_tab[g] = 16'(rate_half(RATE_10BPS[g]));
    end
  end

  i2ctt_state_t s;
  i2ctt_state_t next_s;
  logic link;
  logic [1:0] tmo_sel;
  logic [19:0] limit;
  logic expire;

  assign link = s.lsync[1];
  assign tmo_sel = s.ctl[CTL_TMO_LSB +: 2];

  always_comb
  begin
    case (tmo_sel)
      2'h0: limit = 20'(TMO0_CYC);
      2'h1: limit = 20'(TMO1_CYC);
      2'h2: limit = 20'(TMO2_CYC);
      default: limit = 20'hFFFFF;
    endcase
  end

  // code 11 never expires, the wait is unbounded
  assign expire = (s.st == I2CTT_WAIT) && (tmo_sel != TMO_NONE) && (s.cnt == limit - 20'h1);

  always_comb
  begin
    next_s = s;
    next_s.lsync = {s.lsync[0], FWD_LINK_UP};
    next_s.abandon = 1'b0;
    next_s.setup = setup_tab[s.ctl[CTL_SH_LSB +: 2]];
    next_s.hold = hold_tab[s.ctl[CTL_SH_LSB +: 2]];
    next_s.half = half_tab[s.ctl[CTL_RATE_LSB +: 3]];
    case (s.st)
      I2CTT_IDLE:
      begin
        next_s.cnt = 20'h0;
        if (XFER_START && link)
          next_s.st = I2CTT_WAIT;
      end
      I2CTT_WAIT:
      begin
        next_s.cnt = s.cnt + 20'h1;
        if (REMOTE_RESP)
          next_s.st = I2CTT_IDLE;
        else if (expire)
        begin
          next_s.st = I2CTT_IDLE;
          next_s.abandon = 1'b1;
        end
      end
      default:
        next_s.st = I2CTT_IDLE;
    endcase
    if (WR && ADDR == ADDR_CTRL)
      next_s.ctl = WDATA;
    else if (WR && ADDR == ADDR_STAT && WDATA[STAT_TMO_BIT])
      next_s.tmo_flag = 1'b0;
    // a timeout in the clearing cycle stays visible
    if (s.st == I2CTT_WAIT && !REMOTE_RESP && expire)
      next_s.tmo_flag = 1'b1;
    next_s.rdata = 8'h00;
    if (RD && ADDR == ADDR_CTRL)
      next_s.rdata = s.ctl;
    else if (RD && ADDR == ADDR_STAT)
    begin
      next_s.rdata[STAT_WAIT_BIT] = (s.st == I2CTT_WAIT);
      next_s.rdata[STAT_TMO_BIT] = s.tmo_flag;
      next_s.rdata[STAT_LINK_BIT] = link;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      s <= '0;
      s.ctl <= CTL_RESET;
      s.st <= I2CTT_IDLE;
    end
    else
      s <= next_s;
  end

  // acknowledge only in the slot, only with the option set
  assign LOCAL_ACK = ACK_SLOT && !link && s.ctl[CTL_LACK_BIT];
  assign STRETCH = (s.st == I2CTT_WAIT);
  assign ABANDON = s.abandon;
  assign RDATA = s.rdata;
  assign SETUP_CYC = s.setup;
  assign HOLD_CYC = s.hold;
  assign HALF_BIT_CYC = s.half;

  sequence start_wait_s;
    XFER_START && link && (s.st == I2CTT_IDLE);
  endsequence

  sequence expire_s;
    expire && !REMOTE_RESP;
  endsequence

  no_ack_down_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (!link && !s.ctl[CTL_LACK_BIT]) |-> !LOCAL_ACK) else $error("local ack driven with option clear");
  local_ack_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (ACK_SLOT && !link && s.ctl[CTL_LACK_BIT]) |-> LOCAL_ACK) else $error("local ack missing");
  reset_value_a: assert property (@(posedge CLK)
    !RSTN |=> (s.ctl == CTL_RESET)) else $error("control reset value wrong");
  setup_map_a: assert property (@(posedge CLK) disable iff (!RSTN)
    1'b1 |=> (SETUP_CYC == setup_tab[$past(s.ctl[CTL_SH_LSB +: 2])]
              && HOLD_CYC == hold_tab[$past(s.ctl[CTL_SH_LSB +: 2])])) else $error("setup/hold count wrong");
  rate_map_a: assert property (@(posedge CLK) disable iff (!RSTN)
    ($past(s.ctl[CTL_RATE_LSB +: 3]) == 3'h3) |-> (HALF_BIT_CYC == 16'(rate_half(10500))))
    else $error("rate code 011 count wrong");
  rate_field_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == ADDR_CTRL && WDATA[CTL_RATE_LSB +: 3] == 3'h4) ##2 1'b1 |-> (HALF_BIT_CYC == 16'(rate_half(17300))))
    else $error("rate code 100 count wrong");
  start_wait_a: assert property (@(posedge CLK) disable iff (!RSTN)
    start_wait_s ##1 (!REMOTE_RESP)[*2] |-> STRETCH) else $error("wait not entered");
  expire_time_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (STRETCH && s.cnt == 20'h0 && tmo_sel == 2'h0) ##1 (!REMOTE_RESP && tmo_sel == 2'h0)[*8]
      |-> STRETCH) else $error("timeout far too early");
  no_timeout_a: assert property (@(posedge CLK) disable iff (!RSTN)
    ($past(tmo_sel) == TMO_NONE) |-> !ABANDON) else $error("abandon with no timeout");
  release_a: assert property (@(posedge CLK) disable iff (!RSTN)
    expire_s |=> (ABANDON && !STRETCH && s.tmo_flag)) else $error("bus not released on timeout");

  sequence resp_s;
    (s.st == I2CTT_WAIT) && REMOTE_RESP;
  endsequence

  sequence refused_s;
    XFER_START && !link && (s.st == I2CTT_IDLE);
  endsequence

  resp_end_a: assert property (@(posedge CLK) disable iff (!RSTN)
    resp_s |=> (!STRETCH && !ABANDON)) else $error("wait not ended by response");
  start_refused_a: assert property (@(posedge CLK) disable iff (!RSTN)
    refused_s |=> !STRETCH) else $error("transfer taken with link down");
  abandon_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN)
    ABANDON |=> !ABANDON) else $error("abandon longer than one cycle");
  tmo_sticky_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (s.tmo_flag && !(WR && ADDR == ADDR_STAT && WDATA[STAT_TMO_BIT])) |=> s.tmo_flag)
    else $error("timeout flag lost");
  rdata_idle_a: assert property (@(posedge CLK) disable iff (!RSTN)
    !RD |=> (RDATA == 8'h00)) else $error("read data outside read cycle");
  link_sync_a: assert property (@(posedge CLK) disable iff (!RSTN)
    ($past(RSTN) && $past(RSTN, 2)) |-> (link == $past(FWD_LINK_UP, 2)))
    else $error("link sync latency wrong");

endmodule : i2ctt_core

/* File: i2ctt_pkg.sv */
package i2ctt_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam logic [7:0] ADDR_CTRL = 8'h1C;
  localparam logic [7:0] ADDR_STAT = 8'h1D;
  localparam int CTL_LACK_BIT = 7;
  localparam int CTL_SH_LSB = 5;
  localparam int CTL_RATE_LSB = 2;
  localparam int CTL_TMO_LSB = 0;
  localparam logic [7:0] CTL_RESET = 8'hB4;
  localparam logic [1:0] TMO_NONE = 2'h3;
  localparam int STAT_WAIT_BIT = 0;
  localparam int STAT_TMO_BIT = 1;
  localparam int STAT_LINK_BIT = 2;
  localparam int unsigned SETUP_NS [4] = '{352, 469, 938, 1046};
  localparam int unsigned HOLD_NS [4] = '{117, 234, 352, 469};
  // typical rates in units of 10 bit/s
  localparam int unsigned RATE_10BPS [8] = '{847, 2830, 6000, 10500, 17300, 33900, 53300, 83700};
  localparam int unsigned TMO_US [3] = '{64, 256, 1024};

  // least times round up to whole cycles
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction : ns_to_cyc

  // half bit period, rounded down
  function automatic int unsigned rate_half(input int unsigned r10);
    return (CLK_MHZ * 100000) / (2 * r10);
  endfunction : rate_half

  typedef enum logic [0:0] {
    I2CTT_IDLE = 1'b0,
    I2CTT_WAIT = 1'b1
  } i2ctt_fsm_t;

  typedef struct packed {
    logic [7:0] ctl;
    i2ctt_fsm_t st;
    logic [19:0] cnt;
    logic tmo_flag;
    logic abandon;
    logic [1:0] lsync;
    logic [7:0] rdata;
    logic [7:0] setup;
    logic [7:0] hold;
    logic [15:0] half;
  } i2ctt_state_t;
endpackage : i2ctt_pkg

/* File: i2ctt_host_model.sv */
`timescale 1ns/1ps
// far-side stand-in: starts a forwarded transfer, answers after resp_dly cycles
module i2ctt_host_model
(
  // clock
  input wire logic CLK,
  // control from the bench
  input wire logic go,
  input wire logic [7:0] resp_dly,
  // toward the block
  output logic XFER_START,
  output logic REMOTE_RESP
);
  logic [7:0] cnt;
  initial
  begin
    XFER_START = 1'b0;
    REMOTE_RESP = 1'b0;
    cnt = 8'h00;
  end
  // zero delay means the far side never answers
  always @(posedge CLK)
  begin
    XFER_START <= go;
    REMOTE_RESP <= (cnt == 8'h01);
    if (go)
      cnt <= resp_dly;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
endmodule : i2ctt_host_model

/* File: tb_i2c_tunnel_timing_config.sv */
`timescale 1ns/1ps
module tb_i2c_tunnel_timing_config
  import i2ctt_pkg::*;
;
  logic CLK = 0, RSTN = 0, WR = 0, RD = 0, FWD_LINK_UP = 0, ACK_SLOT = 0, go = 0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, SETUP_CYC, HOLD_CYC, dly = 8'h00;
  logic [15:0] HALF_BIT_CYC;
  logic XFER_START, REMOTE_RESP, LOCAL_ACK, STRETCH, ABANDON;
  int errors = 0, check_count = 0, n;
  int su [4] = '{71, 94, 188, 210};
  int ho [4] = '{24, 47, 71, 94};
  int hb [8] = '{200, 3533, 1666, 952, 578, 294, 187, 119};
  int tl [3] = '{20, 40, 80};
  i2ctt_core #(.RATE0_HALF_CYC(200), .TMO0_CYC(20), .TMO1_CYC(40), .TMO2_CYC(80)) u_dut (.CLK(CLK),
    .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FWD_LINK_UP(FWD_LINK_UP),
    .ACK_SLOT(ACK_SLOT), .XFER_START(XFER_START), .REMOTE_RESP(REMOTE_RESP), .LOCAL_ACK(LOCAL_ACK),
    .STRETCH(STRETCH), .ABANDON(ABANDON), .SETUP_CYC(SETUP_CYC), .HOLD_CYC(HOLD_CYC), .HALF_BIT_CYC(HALF_BIT_CYC));
  i2ctt_host_model u_host (.CLK(CLK), .go(go), .resp_dly(dly), .XFER_START(XFER_START), .REMOTE_RESP(REMOTE_RESP));
  initial
  begin
    forever #2.5 CLK = ~CLK;
  end
  task automatic final_report;
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLK) WR <= 1'b0;
    repeat (2) @(posedge CLK);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK) {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK) RD <= 1'b0;
    #1 chk("rdata", {8'h00, exp}, {8'h00, RDATA});
  endtask : rd
  task automatic start(input logic [7:0] d, input logic e);
    @(posedge CLK) {go, dly} <= {1'b1, d};
    @(posedge CLK) go <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 chk("stretch", {15'h0, e}, {15'h0, STRETCH});
  endtask : start
  initial
  begin
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (2) @(posedge CLK);
    rd(ADDR_CTRL, CTL_RESET);
    chk("setup", 16'h5E, {8'h00, SETUP_CYC});
    chk("half", 16'h126, HALF_BIT_CYC);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL, {1'b1, i[1:0], 5'h14});
      chk("setup", 16'(su[i]), {8'h00, SETUP_CYC});
      chk("hold", 16'(ho[i]), {8'h00, HOLD_CYC});
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_CTRL, {3'h4, i[2:0], 2'h0});
      chk("half", 16'(hb[i]), HALF_BIT_CYC);
    end
    @(posedge CLK) ACK_SLOT <= 1'b1;
    #1 chk("lack_set", 16'h1, {15'h0, LOCAL_ACK});
    wr(ADDR_CTRL, 8'h34);
    chk("lack_clr", 16'h0, {15'h0, LOCAL_ACK});
    start(8'h00, 1'b0);
    @(posedge CLK) FWD_LINK_UP <= 1'b1;
    for (int c = 0; c < 3; c++)
    begin
      wr(ADDR_CTRL, {6'h2D, c[1:0]});
      chk("lack_up", 16'h0, {15'h0, LOCAL_ACK});
      start(8'h00, 1'b1);
      n = 0;
      while (ABANDON !== 1'b1)
      begin
        @(posedge CLK);
        #1 n++;
        if (n > 300)
        begin
          errors++;
          final_report;
        end
      end
      chk("tmo_len", 16'(tl[c] - 1), 16'(n));
      chk("release", 16'h0, {15'h0, STRETCH});
      rd(ADDR_STAT, 8'h06);
      wr(ADDR_STAT, 8'h02);
    end
    wr(ADDR_CTRL, 8'hB7);
    start(8'h96, 1'b1);
    repeat (120) @(posedge CLK);
    #1 chk("no_tmo", 16'h1, {15'h0, STRETCH});
    rd(ADDR_STAT, 8'h05);
    repeat (40) @(posedge CLK);
    #1 chk("resp_end", 16'h0, {15'h0, STRETCH});
    final_report;
  end
endmodule : tb_i2c_tunnel_timing_config
